// ---- common/fifo_pkg.sv ----
// Shared constants, state machine codes and state layout of the retransmit FIFO.
package fifo_pkg;
	localparam int DATA_W = 18;
	localparam int DEPTH = 8192;
	localparam int AW = 13;
	localparam int PTR_W = 14;
	localparam int OFF_W = 13;
	localparam int BUF_DEPTH = 4;
	localparam logic [PTR_W-1:0] DEPTH_P = 14'h2000;
	localparam logic [PTR_W-1:0] HALF_P = 14'h1000;
	localparam logic [OFF_W-1:0] OFF_PAR = 13'h007F;
	localparam logic [OFF_W-1:0] OFF_SER = 13'h03FF;
	localparam logic [DATA_W-1:0] WORD_ZERO = 18'h00000;

	typedef enum logic [2:0] {
		RT_IDLE = 3'b001,
		RT_WAIT = 3'b010,
		RT_DONE = 3'b100
	} rt_e;

	typedef struct packed {
		logic ft_mode;
		logic serial_mode;
		logic [2*OFF_W-1:0] offs;
		logic wr_off_sel;
		logic rd_off_sel;
		logic [PTR_W-1:0] wptr;
		logic [PTR_W-1:0] rptr;
		logic [PTR_W-1:0] wgray_s1;
		logic [PTR_W-1:0] wgray_s2;
		logic [PTR_W-1:0] rgray_s1;
		logic [PTR_W-1:0] rgray_s2;
		logic [DATA_W-1:0] rdata;
		logic out_empty;
		logic full;
		logic ae_n;
		logic af_n;
		logic hf_n;
		rt_e rt;
	} state_s;

	localparam state_s RESET_S = '{
		ft_mode: 1'b0, serial_mode: 1'b0, offs: {OFF_PAR, OFF_PAR},
		wr_off_sel: 1'b0, rd_off_sel: 1'b0,
		wptr: '0, rptr: '0, wgray_s1: '0, wgray_s2: '0, rgray_s1: '0, rgray_s2: '0,
		rdata: WORD_ZERO, out_empty: 1'b1, full: 1'b0,
		ae_n: 1'b0, af_n: 1'b1, hf_n: 1'b1, rt: RT_IDLE
	};
endpackage

// ---- logic/retx_fifo.sv ----
// Deep FIFO with full and soft reset, mode latch, offset registers and retransmit.
`timescale 1ns/10ps

module word_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 4
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] data;
		logic [PW:0] wp;
		logic [PW:0] rp;
	} buf_s;
	buf_s s;
	buf_s next_s;

	assign in_ready = !((s.wp[PW] != s.rp[PW]) && (s.wp[PW-1:0] == s.rp[PW-1:0]));
	assign out_valid = (s.wp != s.rp);
	assign out_data = s.data[s.rp[PW-1:0]];

	always_comb begin
		next_s = s;
		if (in_valid && in_ready) begin
			next_s.data[s.wp[PW-1:0]] = in_data;
			next_s.wp = s.wp + 1'b1;
		end
		if (out_valid && out_ready) begin
			next_s.rp = s.rp + 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule

module retx_fifo (
	input wire logic CLK,
	input wire logic RST,
	input wire logic FULL_RESET_N,
	input wire logic SOFT_RESET_N,
	input wire logic RETRANSMIT_N,
	input wire logic OFFSET_LOAD_N,
	input wire logic SERIAL_ENABLE_N,
	input wire logic FALL_THROUGH_SERIAL_IN,
	input wire logic WRITE_STROBE_N,
	input wire logic READ_STROBE_N,
	input wire logic [fifo_pkg::DATA_W-1:0] WRITE_WORD,
	output logic WRITE_READY,
	output logic [fifo_pkg::DATA_W-1:0] READ_WORD,
	output logic EMPTY_INDICATOR_N,
	output logic OUTPUT_VALID_N,
	output logic FULL_INDICATOR_N,
	output logic INPUT_SPACE_N,
	output logic ALMOST_EMPTY_N,
	output logic ALMOST_FULL_N,
	output logic HALF_FULL_N
);
	fifo_pkg::state_s s;
	fifo_pkg::state_s next_s;
	logic [fifo_pkg::DATA_W-1:0] mem [fifo_pkg::DEPTH];
	logic [fifo_pkg::DATA_W-1:0] mem_q;
	logic [fifo_pkg::DATA_W-1:0] buf_data;
	logic buf_valid;
	logic drain;
	logic [fifo_pkg::PTR_W-1:0] wsync;
	logic [fifo_pkg::PTR_W-1:0] rsync;
	logic [fifo_pkg::PTR_W-1:0] rcount;
	logic [fifo_pkg::PTR_W-1:0] wcount;

	function automatic logic [fifo_pkg::PTR_W-1:0] to_gray(input logic [fifo_pkg::PTR_W-1:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [fifo_pkg::PTR_W-1:0] from_gray(input logic [fifo_pkg::PTR_W-1:0] g);
		logic [fifo_pkg::PTR_W-1:0] b;
		b[fifo_pkg::PTR_W-1] = g[fifo_pkg::PTR_W-1];
		for (int i = fifo_pkg::PTR_W - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	// Incoming words park here so a full memory or a held full or soft reset stalls the writer via WRITE_READY.
	word_fifo #(.WIDTH(fifo_pkg::DATA_W), .DEPTH(fifo_pkg::BUF_DEPTH)) u_in_buf (
		.CLK(CLK),
		.RST(RST),
		.in_valid(!WRITE_STROBE_N && OFFSET_LOAD_N),
		.in_ready(WRITE_READY),
		.in_data(WRITE_WORD),
		.out_valid(buf_valid),
		.out_ready(drain),
		.out_data(buf_data)
	);

	// Only the second stage of each pointer copy is decoded; the first only feeds the second.
	assign wsync = from_gray(s.wgray_s2);
	assign rsync = from_gray(s.rgray_s2);
	assign rcount = wsync - s.rptr;
	assign wcount = s.wptr - rsync;
	// The live count gates the drain, since the registered full flag lags one edge and would let a word overwrite.
	assign drain = buf_valid && (wcount != fifo_pkg::DEPTH_P) && FULL_RESET_N && SOFT_RESET_N;
	assign mem_q = mem[s.rptr[fifo_pkg::AW-1:0]];

	always_ff @(posedge CLK) begin
		if (drain) begin
			mem[s.wptr[fifo_pkg::AW-1:0]] <= buf_data;
		end
	end

	always_comb begin
		next_s = s;
		next_s.wgray_s1 = to_gray(s.wptr);
		next_s.wgray_s2 = s.wgray_s1;
		next_s.rgray_s1 = to_gray(s.rptr);
		next_s.rgray_s2 = s.rgray_s1;
		if (drain) begin
			next_s.wptr = s.wptr + 1'b1;
		end
		if (!OFFSET_LOAD_N && !WRITE_STROBE_N && !s.serial_mode) begin
			if (s.wr_off_sel) begin
				next_s.offs[2*fifo_pkg::OFF_W-1:fifo_pkg::OFF_W] = WRITE_WORD[fifo_pkg::OFF_W-1:0];
			end else begin
				next_s.offs[fifo_pkg::OFF_W-1:0] = WRITE_WORD[fifo_pkg::OFF_W-1:0];
			end
			next_s.wr_off_sel = !s.wr_off_sel;
		end
		if (!OFFSET_LOAD_N && !SERIAL_ENABLE_N && s.serial_mode) begin
			next_s.offs = {FALL_THROUGH_SERIAL_IN, s.offs[2*fifo_pkg::OFF_W-1:1]};
		end
		// Full and almost-full follow the read pointer copy two edges late; half-full uses the live pointers.
		next_s.full = (wcount == fifo_pkg::DEPTH_P);
		next_s.af_n = !(wcount + {1'b0, s.offs[2*fifo_pkg::OFF_W-1:fifo_pkg::OFF_W]} >= fifo_pkg::DEPTH_P);
		next_s.hf_n = !((s.wptr - s.rptr) > fifo_pkg::HALF_P);
		next_s.ae_n = !(rcount <= {1'b0, s.offs[fifo_pkg::OFF_W-1:0]});
		unique case (s.rt)
			fifo_pkg::RT_IDLE: begin
				if (!RETRANSMIT_N) begin
					next_s.rptr = '0;
					next_s.out_empty = 1'b1;
					next_s.rt = fifo_pkg::RT_WAIT;
				end else if (!OFFSET_LOAD_N && !READ_STROBE_N) begin
					next_s.rdata = s.rd_off_sel ?
						{{(fifo_pkg::DATA_W-fifo_pkg::OFF_W){1'b0}}, s.offs[2*fifo_pkg::OFF_W-1:fifo_pkg::OFF_W]} :
						{{(fifo_pkg::DATA_W-fifo_pkg::OFF_W){1'b0}}, s.offs[fifo_pkg::OFF_W-1:0]};
					next_s.rd_off_sel = !s.rd_off_sel;
				end else if (s.ft_mode) begin
					if (s.out_empty || !READ_STROBE_N) begin
						if (rcount != '0) begin
							next_s.rdata = mem_q;
							next_s.rptr = s.rptr + 1'b1;
							next_s.out_empty = 1'b0;
						end else begin
							next_s.out_empty = 1'b1;
						end
					end
				end else begin
					if (!READ_STROBE_N && !s.out_empty) begin
						next_s.rdata = mem_q;
						next_s.rptr = s.rptr + 1'b1;
					end
					next_s.out_empty = (wsync == next_s.rptr);
				end
			end
			fifo_pkg::RT_WAIT: begin
				next_s.rt = fifo_pkg::RT_DONE;
				next_s.ae_n = s.ae_n;
			end
			fifo_pkg::RT_DONE: begin
				next_s.rt = fifo_pkg::RT_IDLE;
				next_s.out_empty = (rcount == '0);
				if (s.ft_mode && rcount != '0) begin
					next_s.rdata = mem_q;
					next_s.rptr = s.rptr + 1'b1;
				end
			end
		endcase
		if (!FULL_RESET_N) begin
			next_s = fifo_pkg::RESET_S;
			next_s.ft_mode = FALL_THROUGH_SERIAL_IN;
			next_s.serial_mode = OFFSET_LOAD_N;
			next_s.offs = OFFSET_LOAD_N ? {fifo_pkg::OFF_SER, fifo_pkg::OFF_SER} :
				{fifo_pkg::OFF_PAR, fifo_pkg::OFF_PAR};
		end else if (!SOFT_RESET_N) begin
			next_s = fifo_pkg::RESET_S;
			next_s.ft_mode = s.ft_mode;
			next_s.serial_mode = s.serial_mode;
			next_s.offs = s.offs;
			next_s.wr_off_sel = s.wr_off_sel;
			next_s.rd_off_sel = s.rd_off_sel;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			s <= fifo_pkg::RESET_S;
		end else begin
			s <= next_s;
		end
	end

	// The pin of the unselected mode is parked high, except input space which reads as available.
	assign READ_WORD = s.rdata;
	assign EMPTY_INDICATOR_N = s.ft_mode | !s.out_empty;
	assign OUTPUT_VALID_N = !s.ft_mode | s.out_empty;
	assign FULL_INDICATOR_N = s.ft_mode | !s.full;
	assign INPUT_SPACE_N = s.ft_mode & s.full;
	assign ALMOST_EMPTY_N = s.ae_n;
	assign ALMOST_FULL_N = s.af_n;
	assign HALF_FULL_N = s.hf_n;

	logic quiet;
	assign quiet = FULL_RESET_N && SOFT_RESET_N;

	sequence s_rt_go;
		quiet && RETRANSMIT_N == 1'b0 && s.rt == fifo_pkg::RT_IDLE;
	endsequence

	sequence s_setup_run;
		quiet[*2];
	endsequence

	property p_rt_rewind;
		@(posedge CLK) disable iff (RST) s_rt_go |=> s.rptr == '0 && s.rt == fifo_pkg::RT_WAIT;
	endproperty
	a_rt_rewind: assert property (p_rt_rewind) else $error("retransmit did not rewind");

	property p_rt_std;
		@(posedge CLK) disable iff (RST) s_rt_go ##0 !s.ft_mode ##1 s_setup_run ##0 rcount != '0
			|-> ##1 EMPTY_INDICATOR_N;
	endproperty
	a_rt_std: assert property (p_rt_std) else $error("empty flag not raised after setup");

	property p_rt_std_low;
		@(posedge CLK) disable iff (RST) s_rt_go ##0 !s.ft_mode |=> !EMPTY_INDICATOR_N[*2];
	endproperty
	a_rt_std_low: assert property (p_rt_std_low) else $error("empty flag not low in setup");

	property p_rt_ft;
		@(posedge CLK) disable iff (RST) s_rt_go ##0 s.ft_mode ##1 s_setup_run ##0 rcount != '0
			|-> ##1 !OUTPUT_VALID_N && READ_WORD == mem[0];
	endproperty
	a_rt_ft: assert property (p_rt_ft) else $error("first word not shown after setup");

	property p_rt_ft_hi;
		@(posedge CLK) disable iff (RST) s_rt_go ##0 s.ft_mode |=> OUTPUT_VALID_N[*2];
	endproperty
	a_rt_ft_hi: assert property (p_rt_ft_hi) else $error("valid flag not high in setup");

	property p_full_rst;
		@(posedge CLK) disable iff (RST) !FULL_RESET_N |=> s.wptr == '0 && s.rptr == '0 && !ALMOST_EMPTY_N
			&& ALMOST_FULL_N && HALF_FULL_N && READ_WORD == fifo_pkg::WORD_ZERO
			&& s.ft_mode == $past(FALL_THROUGH_SERIAL_IN);
	endproperty
	a_full_rst: assert property (p_full_rst) else $error("full reset state wrong");

	property p_off_default;
		@(posedge CLK) disable iff (RST) !FULL_RESET_N |=> s.offs == ($past(OFFSET_LOAD_N) ?
			{fifo_pkg::OFF_SER, fifo_pkg::OFF_SER} : {fifo_pkg::OFF_PAR, fifo_pkg::OFF_PAR});
	endproperty
	a_off_default: assert property (p_off_default) else $error("offset defaults wrong");

	property p_soft_keep;
		@(posedge CLK) disable iff (RST) FULL_RESET_N && !SOFT_RESET_N |=> s.offs == $past(s.offs)
			&& s.ft_mode == $past(s.ft_mode) && READ_WORD == fifo_pkg::WORD_ZERO && s.rptr == '0;
	endproperty
	a_soft_keep: assert property (p_soft_keep) else $error("soft reset lost settings");

	property p_serial;
		@(posedge CLK) disable iff (RST) quiet && s.serial_mode && !OFFSET_LOAD_N && !SERIAL_ENABLE_N
			|=> s.offs == {$past(FALL_THROUGH_SERIAL_IN), $past(s.offs[2*fifo_pkg::OFF_W-1:1])};
	endproperty
	a_serial: assert property (p_serial) else $error("serial offset shift wrong");

	property p_ft_first;
		@(posedge CLK) disable iff (RST) quiet && s.ft_mode && s.out_empty && drain && rcount == '0
			&& s.wptr == s.rptr && s.rt == fifo_pkg::RT_IDLE ##1 (quiet && RETRANSMIT_N && OFFSET_LOAD_N)[*3]
			|=> !OUTPUT_VALID_N;
	endproperty
	a_ft_first: assert property (p_ft_first) else $error("first word did not fall through");

	property p_ae_hold;
		@(posedge CLK) disable iff (RST) s_rt_go ##1 quiet |=> $stable(ALMOST_EMPTY_N);
	endproperty
	a_ae_hold: assert property (p_ae_hold) else $error("almost-empty moved on first setup edge");

	property p_mode_flags;
		@(posedge CLK) disable iff (RST) !quiet |=> OUTPUT_VALID_N && FULL_INDICATOR_N && !INPUT_SPACE_N
			&& EMPTY_INDICATOR_N == s.ft_mode;
	endproperty
	a_mode_flags: assert property (p_mode_flags) else $error("mode flags wrong after reset");

	property p_soft_flags;
		@(posedge CLK) disable iff (RST) FULL_RESET_N && !SOFT_RESET_N |=> s.wptr == '0 && !ALMOST_EMPTY_N
			&& ALMOST_FULL_N && HALF_FULL_N;
	endproperty
	a_soft_flags: assert property (p_soft_flags) else $error("soft reset flags wrong");

	property p_fill;
		@(posedge CLK) disable iff (RST) quiet |-> wcount <= fifo_pkg::DEPTH_P;
	endproperty
	a_fill: assert property (p_fill) else $error("write count passed the depth");

	property p_ft_hold;
		@(posedge CLK) disable iff (RST) quiet && s.ft_mode && !s.out_empty && READ_STROBE_N && RETRANSMIT_N
			&& OFFSET_LOAD_N && s.rt == fifo_pkg::RT_IDLE |=> $stable(READ_WORD);
	endproperty
	a_ft_hold: assert property (p_ft_hold) else $error("output word moved without a strobe");

	property p_std_read;
		@(posedge CLK) disable iff (RST) quiet && !s.ft_mode && READ_STROBE_N && RETRANSMIT_N
			&& OFFSET_LOAD_N |=> $stable(READ_WORD);
	endproperty
	a_std_read: assert property (p_std_read) else $error("word read without a strobe");
endmodule

// ---- test/host_model.sv ----
// Host-side model that drives the write and read strobes of the FIFO.
`timescale 1ns/10ps
module host_model (
	input wire logic clk,
	input wire logic wr_ready,
	input wire logic rd_ok,
	input wire logic [fifo_pkg::DATA_W-1:0] q_in,
	output logic wr_n,
	output logic rd_n,
	output logic [fifo_pkg::DATA_W-1:0] word
);
	initial begin
		wr_n = 1'b1;
		rd_n = 1'b1;
		word = 18'h3FFFF;
	end
	// The word is inverted after the write so that stale data can never pass for the next one.
	task automatic push(input logic [fifo_pkg::DATA_W-1:0] w, output bit ok);
		int n;
		ok = 1'b0;
		@(posedge clk);
		wr_n <= 1'b0;
		word <= w;
		for (n = 0; n < 40 && !ok; n++) begin
			@(negedge clk);
			ok = (wr_ready === 1'b1);
			@(posedge clk);
		end
		wr_n <= 1'b1;
		word <= ~w;
	endtask
	// Every read word is requested by its own strobe, except the first word in fall-through mode, which shows without one.
	task automatic pull(input bit gate, output logic [fifo_pkg::DATA_W-1:0] q, output bit ok);
		int n;
		ok = 1'b0;
		@(posedge clk);
		rd_n <= 1'b0;
		for (n = 0; n < 40 && !ok; n++) begin
			@(negedge clk);
			ok = !gate || (rd_ok === 1'b1);
			@(posedge clk);
		end
		rd_n <= 1'b1;
		@(posedge clk);
		#1;
		q = q_in;
	endtask
endmodule

// ---- test/retx_fifo_tb.sv ----
// Self-checking testbench for the retransmit FIFO.
`timescale 1ns/10ps
module retx_fifo_tb;
	logic clk, rst, frst_n, srst_n, rt_n, ld_n, sen_n, si;
	logic wr_n, rd_n, wr_ready, ef_n, ov_n, ff_n, is_n, ae_n, af_n, hf_n;
	logic [17:0] wword, rword, q;
	logic [25:0] ser;
	int failures = 0;
	int checked = 0;
	bit ok;
	int i;
	retx_fifo i_dut (.CLK(clk), .RST(rst), .FULL_RESET_N(frst_n), .SOFT_RESET_N(srst_n), .RETRANSMIT_N(rt_n),
		.OFFSET_LOAD_N(ld_n), .SERIAL_ENABLE_N(sen_n), .FALL_THROUGH_SERIAL_IN(si), .WRITE_STROBE_N(wr_n),
		.READ_STROBE_N(rd_n), .WRITE_WORD(wword), .WRITE_READY(wr_ready), .READ_WORD(rword),
		.EMPTY_INDICATOR_N(ef_n), .OUTPUT_VALID_N(ov_n), .FULL_INDICATOR_N(ff_n), .INPUT_SPACE_N(is_n),
		.ALMOST_EMPTY_N(ae_n), .ALMOST_FULL_N(af_n), .HALF_FULL_N(hf_n));
	host_model i_host (.clk(clk), .wr_ready(wr_ready), .rd_ok(ef_n), .q_in(rword), .wr_n(wr_n), .rd_n(rd_n),
		.word(wword));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic close_out;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("BAD at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic check1(input logic seen, input logic exp);
		check({17'h00000, seen}, {17'h00000, exp});
	endtask
	task automatic bound(input bit good);
		if (!good) begin
			failures++;
			$display("BAD at %0t: wait ran out", $time);
			close_out();
		end
	endtask
	// A flag that never reaches its level ends the run instead of hanging it.
	task automatic wait_flag(input bit ft);
		int n;
		for (n = 0; n < 20 && (ft ? ov_n !== 1'b0 : ef_n !== 1'b1); n++) @(posedge clk);
		bound(n < 20);
		#1;
	endtask
	task automatic reset_full(input logic ft, input logic ld);
		@(posedge clk);
		frst_n <= 1'b0;
		si <= ft;
		ld_n <= ld;
		repeat (2) @(posedge clk);
		frst_n <= 1'b1;
		ld_n <= 1'b1;
		si <= 1'b0;
		@(posedge clk);
		#1;
	endtask
	task automatic offs(input logic [12:0] e, input logic [12:0] f);
		@(posedge clk);
		ld_n <= 1'b0;
		i_host.pull(1'b0, q, ok);
		check(q & 18'h01FFF, {5'h00, e});
		i_host.pull(1'b0, q, ok);
		check(q & 18'h01FFF, {5'h00, f});
		@(posedge clk);
		ld_n <= 1'b1;
	endtask
	task automatic offs_load(input logic [12:0] e, input logic [12:0] f);
		@(posedge clk);
		ld_n <= 1'b0;
		i_host.push({5'h00, e}, ok);
		i_host.push({5'h00, f}, ok);
		@(posedge clk);
		ld_n <= 1'b1;
	endtask
	task automatic retx(input bit ft);
		@(posedge clk);
		rt_n <= 1'b0;
		@(posedge clk);
		rt_n <= 1'b1;
		#1;
		check1(ft ? ov_n : ef_n, ft);
		wait_flag(ft);
	endtask
	initial begin
		rst = 1'b1;
		frst_n = 1'b1;
		srst_n = 1'b1;
		rt_n = 1'b1;
		ld_n = 1'b1;
		sen_n = 1'b1;
		si = 1'b0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		reset_full(1'b0, 1'b0);
		check(rword, 18'h00000);
		check1(ae_n, 1'b0);
		check1(af_n & hf_n, 1'b1);
		check1(ef_n, 1'b0);
		check1(ff_n, 1'b1);
		offs(13'h007F, 13'h007F);
		offs_load(13'h0002, 13'h1FFE);
		offs(13'h0002, 13'h1FFE);
		$display("test reset and handshake mode done");
		for (i = 0; i < 5; i++) begin
			i_host.push(18'h15A00 + 18'(i), ok);
			bound(ok);
		end
		wait_flag(1'b0);
		for (i = 0; i < 5; i++) begin
			i_host.pull(1'b1, q, ok);
			check(q, 18'h15A00 + 18'(i));
		end
		check1(ef_n, 1'b0);
		retx(1'b0);
		repeat (2) @(posedge clk);
		#1;
		check1(ae_n, 1'b1);
		check1(hf_n, 1'b1);
		check1(af_n, 1'b0);
		for (i = 0; i < 5; i++) begin
			i_host.pull(1'b1, q, ok);
			check(q, 18'h15A00 + 18'(i));
		end
		$display("test handshake retransmit done");
		reset_full(1'b1, 1'b1);
		check1(ov_n, 1'b1);
		check1(is_n, 1'b0);
		offs(13'h03FF, 13'h03FF);
		ser = {13'h000A, 13'h0005};
		for (i = 0; i < 26; i++) begin
			@(posedge clk);
			ld_n <= 1'b0;
			sen_n <= 1'b0;
			si <= ser[i];
		end
		@(posedge clk);
		ld_n <= 1'b1;
		sen_n <= 1'b1;
		offs_load(13'h0123, 13'h0456);
		offs(13'h0005, 13'h000A);
		for (i = 0; i < 4; i++) begin
			i_host.push(18'h2C300 + 18'(i), ok);
			bound(ok);
		end
		wait_flag(1'b1);
		check(rword, 18'h2C300);
		i_host.pull(1'b1, q, ok);
		check(q, 18'h2C301);
		retx(1'b1);
		check(rword, 18'h2C300);
		$display("test fall-through retransmit done");
		@(posedge clk);
		srst_n <= 1'b0;
		@(posedge clk);
		srst_n <= 1'b1;
		#1;
		check(rword, 18'h00000);
		check1(ae_n, 1'b0);
		check1(ov_n, 1'b1);
		check1(is_n, 1'b0);
		offs(13'h0005, 13'h000A);
		$display("test soft reset done");
		close_out();
	end
endmodule
